// ===== rtl/osc_defines.vh
// Register offsets, field positions, codes and counts of the oscillator control.
`ifndef OSC_DEFINES_VH
`define OSC_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OSC_ADDR_CLOCK_SELECT 4'h0
`define OSC_ADDR_INT_CAL 4'h4
`define OSC_ADDR_EXT_CTRL 4'h8
`define OSC_ADDR_STATUS 4'hc

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define OSC_CAL_SS_BIT 7
`define OSC_EXT_VALID_BIT 7
`define OSC_EXT_MODE_MSB 6
`define OSC_EXT_MODE_LSB 4
`define OSC_EXT_FREQ_MSB 2
`define OSC_EXT_FREQ_LSB 0

// ----------------------------------------------------------------------------
// System clock source codes
// ----------------------------------------------------------------------------
`define OSC_SRC_PRECISION 3'h0
`define OSC_SRC_EXTERNAL 3'h1
`define OSC_SRC_RTC 3'h3
`define OSC_SRC_LOW_POWER 3'h4

// ----------------------------------------------------------------------------
// External oscillator mode codes
// ----------------------------------------------------------------------------
`define OSC_MODE_OFF 3'h0
`define OSC_MODE_CMOS 3'h2
`define OSC_MODE_RC 3'h4
`define OSC_MODE_CAP 3'h5
`define OSC_MODE_XTAL 3'h6
`define OSC_MODE_XTAL_DIV2 3'h7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OSC_RST_CLOCK_SELECT 3'h4
`define OSC_RST_CAL 7'h40
`define OSC_RST_EXT_MODE 3'h0
`define OSC_RST_EXT_FREQ 3'h0

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define OSC_SS_PERIOD 384
`define OSC_SS_MAX_STEPS 6
`define OSC_SS_STEP_LEN (`OSC_SS_PERIOD / (2 * `OSC_SS_MAX_STEPS))
`define OSC_VALID_EDGES 64
`define OSC_VALID_GAP 255

`endif

// ===== rtl/osc_valid_det.v
// Stability detector for the external oscillator pin.
`timescale 1ns/10ps
`include "osc_defines.vh"

module osc_valid_det #(
  parameter EDGES = `OSC_VALID_EDGES,
  parameter GAP = `OSC_VALID_GAP
) (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire pin_in,
  output wire rise,
  output reg valid_reg
);

  // --------------------------------------------------------------------------
  // Synchroniser and edge detect
  // --------------------------------------------------------------------------
  reg sync1_reg;
  reg sync2_reg;
  reg sync3_reg;
  reg [7:0] edge_cnt_reg;
  reg [7:0] gap_cnt_reg;

  // The second and third stages feed the edge detector, never the first.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~sync3_reg;

  // --------------------------------------------------------------------------
  // Edge counting
  // --------------------------------------------------------------------------
  // A long quiet gap restarts the count, so only a steady oscillation counts.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt_reg <= 8'h00;
      gap_cnt_reg <= 8'h00;
      valid_reg <= 1'b0;
    end else if (clear) begin
      edge_cnt_reg <= 8'h00;
      gap_cnt_reg <= 8'h00;
      valid_reg <= 1'b0;
    end else if (rise) begin
      gap_cnt_reg <= 8'h00;
      if (edge_cnt_reg == EDGES[7:0] - 8'h01) begin
        valid_reg <= 1'b1;
      end else begin
        edge_cnt_reg <= edge_cnt_reg + 8'h01;
      end
    end else if (gap_cnt_reg == GAP[7:0]) begin
      edge_cnt_reg <= 8'h00;
      valid_reg <= 1'b0;
    end else begin
      gap_cnt_reg <= gap_cnt_reg + 8'h01;
    end
  end

endmodule // osc_valid_det

// ===== rtl/osc_source_ctrl.v
// Oscillator source control with spread spectrum and external oscillator.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`include "osc_defines.vh"

// Behaviour
// - Spread spectrum steps a triangle wave repeating every 384 oscillator cycles.
// - Modulation only lowers frequency, up to six steps of about 0.26 percent.
// - After reset the low power oscillator is the system clock source.
// - Low power oscillator runs only while selected as system clock.
// - External clock feeds both system clock choice and peripheral clock.
// - Crystal mode optionally halves the clock to a 50 percent duty.
// - A readable valid flag rises once external oscillation is stable.
// - RC and capacitor modes use only the second pin.
// - CMOS clock mode takes a digital input on the second pin only.
// - In CMOS clock mode the valid flag always reads zero.
// - Source codes: low power 100, precision 000, external 001.
module osc_source_ctrl #(
  parameter VALID_EDGES = `OSC_VALID_EDGES,
  parameter VALID_GAP = `OSC_VALID_GAP
) (
  input wire core_clk,
  input wire rst_n,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire osc_pin_first_in,
  output reg osc_pin_first_out,
  output reg osc_pin_first_oe,
  output reg osc_pin_first_analog_reg,
  input wire osc_pin_second_in,
  output reg osc_pin_second_out,
  output reg osc_pin_second_oe,
  output reg osc_pin_second_analog_reg,
  output reg [2:0] system_clock_source_field,
  output reg low_power_osc_en_reg,
  output reg [6:0] int_osc_trim_reg,
  output reg [2:0] spread_step_reg,
  output reg [2:0] ext_osc_drive_freq_code,
  output reg ext_osc_en_reg,
  output reg ext_clk_periph_reg,
  output reg ext_clk_sys_reg
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_sync_n;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg spread_spectrum_enable;
  reg [6:0] cal_reg;
  reg [2:0] ext_mode_reg;
  reg [3:0] aw_addr_reg;
  reg aw_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_held_reg;
  reg [8:0] ss_cnt_reg;
  reg [4:0] ss_step_cnt_reg;
  reg ss_down_reg;
  reg ext_div_reg;
  reg ext_mode_change;
  wire ext_rise;
  wire ext_valid_raw;
  wire ext_osc_valid_flag;
  wire do_write;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire det_clear;

  // Legal source codes only; a reserved code leaves the selection alone.
  function src_legal;
    input [2:0] code;
    begin
      src_legal = (code == `OSC_SRC_PRECISION) ||
                  (code == `OSC_SRC_EXTERNAL) ||
                  (code == `OSC_SRC_RTC) ||
                  (code == `OSC_SRC_LOW_POWER);
    end
  endfunction

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  assign do_write = (aw_held_reg | (s_axi_awvalid & s_axi_awready)) &
                    (w_held_reg | (s_axi_wvalid & s_axi_wready));

  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_held_reg <= 1'b1;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_held_reg <= 1'b1;
        end
        s_axi_awready <= ~s_axi_bvalid & ~aw_held_reg &
                         ~(s_axi_awvalid & s_axi_awready);
        s_axi_wready <= ~s_axi_bvalid & ~w_held_reg &
                        ~(s_axi_wvalid & s_axi_wready);
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      system_clock_source_field <= `OSC_RST_CLOCK_SELECT;
      spread_spectrum_enable <= 1'b0;
      cal_reg <= `OSC_RST_CAL;
      ext_mode_reg <= `OSC_RST_EXT_MODE;
      ext_osc_drive_freq_code <= `OSC_RST_EXT_FREQ;
      ext_mode_change <= 1'b0;
    end else begin
      ext_mode_change <= 1'b0;
      if (do_write & wr_strb[0]) begin
        case (wr_addr)
          `OSC_ADDR_CLOCK_SELECT: begin
            if (src_legal(wr_data[2:0])) begin
              system_clock_source_field <= wr_data[2:0];
            end
          end
          `OSC_ADDR_INT_CAL: begin
            spread_spectrum_enable <= wr_data[`OSC_CAL_SS_BIT];
            cal_reg <= wr_data[6:0];
          end
          `OSC_ADDR_EXT_CTRL: begin
            ext_mode_reg <= wr_data[`OSC_EXT_MODE_MSB:`OSC_EXT_MODE_LSB];
            ext_osc_drive_freq_code <=
              wr_data[`OSC_EXT_FREQ_MSB:`OSC_EXT_FREQ_LSB];
            ext_mode_change <= (wr_data[`OSC_EXT_MODE_MSB:`OSC_EXT_MODE_LSB]
                                != ext_mode_reg);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `OSC_ADDR_CLOCK_SELECT:
          s_axi_rdata <= {29'h0, system_clock_source_field};
        `OSC_ADDR_INT_CAL:
          s_axi_rdata <= {24'h0, spread_spectrum_enable, cal_reg};
        `OSC_ADDR_EXT_CTRL:
          s_axi_rdata <= {24'h0, ext_osc_valid_flag, ext_mode_reg, 1'b0,
                          ext_osc_drive_freq_code};
        `OSC_ADDR_STATUS:
          s_axi_rdata <= {24'h0, low_power_osc_en_reg, int_osc_trim_reg};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else begin
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
    end
  end

  // --------------------------------------------------------------------------
  // Spread spectrum modulator
  // --------------------------------------------------------------------------
  // The step only subtracts from the trim, so the frequency never rises.
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ss_cnt_reg <= 9'h000;
      ss_step_cnt_reg <= 5'h00;
      ss_down_reg <= 1'b1;
      spread_step_reg <= 3'h0;
      int_osc_trim_reg <= `OSC_RST_CAL;
    end else begin
      if (!spread_spectrum_enable) begin
        ss_cnt_reg <= 9'h000;
        ss_step_cnt_reg <= 5'h00;
        ss_down_reg <= 1'b1;
        spread_step_reg <= 3'h0;
      end else begin
        ss_cnt_reg <= (ss_cnt_reg == `OSC_SS_PERIOD - 1) ? 9'h000 :
                      ss_cnt_reg + 9'h001;
        if (ss_step_cnt_reg == `OSC_SS_STEP_LEN - 1) begin
          ss_step_cnt_reg <= 5'h00;
          if (ss_down_reg) begin
            spread_step_reg <= spread_step_reg + 3'h1;
            if (spread_step_reg == `OSC_SS_MAX_STEPS - 1) begin
              ss_down_reg <= 1'b0;
            end
          end else begin
            spread_step_reg <= spread_step_reg - 3'h1;
            if (spread_step_reg == 3'h1) begin
              ss_down_reg <= 1'b1;
            end
          end
        end else begin
          ss_step_cnt_reg <= ss_step_cnt_reg + 5'h01;
        end
      end
      int_osc_trim_reg <= (cal_reg > {4'h0, spread_step_reg}) ?
                          cal_reg - {4'h0, spread_step_reg} : 7'h00;
    end
  end

  // --------------------------------------------------------------------------
  // External oscillator drive and clock paths
  // --------------------------------------------------------------------------
  assign det_clear = ~ext_osc_en_reg | ext_mode_change;
  assign ext_osc_valid_flag = ext_valid_raw &
                              (ext_mode_reg != `OSC_MODE_CMOS);

  osc_valid_det #(
    .EDGES(VALID_EDGES),
    .GAP(VALID_GAP)
  ) u_valid_det (
    .clk(core_clk),
    .rst_n(rst_sync_n),
    .clear(det_clear),
    .pin_in(osc_pin_second_in),
    .rise(ext_rise),
    .valid_reg(ext_valid_raw)
  );

  // The pins are never driven digitally: analog modes need drivers off.
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      low_power_osc_en_reg <= 1'b1;
      ext_osc_en_reg <= 1'b0;
      osc_pin_first_out <= 1'b0;
      osc_pin_first_oe <= 1'b0;
      osc_pin_second_out <= 1'b0;
      osc_pin_second_oe <= 1'b0;
      osc_pin_first_analog_reg <= 1'b0;
      osc_pin_second_analog_reg <= 1'b0;
      ext_div_reg <= 1'b0;
      ext_clk_periph_reg <= 1'b0;
      ext_clk_sys_reg <= 1'b0;
    end else begin
      low_power_osc_en_reg <= (system_clock_source_field ==
                               `OSC_SRC_LOW_POWER);
      ext_osc_en_reg <= (ext_mode_reg != `OSC_MODE_OFF);
      osc_pin_first_analog_reg <= (ext_mode_reg == `OSC_MODE_XTAL) ||
                                  (ext_mode_reg == `OSC_MODE_XTAL_DIV2);
      osc_pin_second_analog_reg <= (ext_mode_reg != `OSC_MODE_OFF) &&
                                   (ext_mode_reg != `OSC_MODE_CMOS);
      if (!ext_osc_en_reg) begin
        ext_div_reg <= 1'b0;
      end else if (ext_rise) begin
        ext_div_reg <= ~ext_div_reg;
      end
      if (ext_mode_reg == `OSC_MODE_XTAL_DIV2) begin
        ext_clk_periph_reg <= ext_div_reg;
      end else begin
        ext_clk_periph_reg <= ext_osc_en_reg & ext_rise;
      end
      if (ext_mode_reg == `OSC_MODE_XTAL_DIV2) begin
        ext_clk_sys_reg <= ext_div_reg &
          (system_clock_source_field == `OSC_SRC_EXTERNAL);
      end else begin
        ext_clk_sys_reg <= ext_osc_en_reg & ext_rise &
          (system_clock_source_field == `OSC_SRC_EXTERNAL);
      end
    end
  end

endmodule // osc_source_ctrl

// ===== bench/osc_source_ctrl_props.sv
// Port assertions for the oscillator source control.
`timescale 1ns/10ps
module osc_source_ctrl_props (
  input wire core_clk,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire osc_pin_first_oe,
  input wire osc_pin_second_oe,
  input wire osc_pin_first_analog_reg,
  input wire osc_pin_second_analog_reg,
  input wire [2:0] system_clock_source_field,
  input wire low_power_osc_en_reg,
  input wire [2:0] spread_step_reg,
  input wire ext_clk_periph_reg,
  input wire ext_clk_sys_reg
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire [2:0] src = system_clock_source_field;
  wire [2:0] stp = spread_step_reg;
  // Reset is async, so this one must run while reset is held.
  chk_reset_source: assert property (disable iff (1'b0)
    !rst_n |=> src == 3'h4) else $error("source not low power in reset");
  chk_lp_follow: assert property (
    low_power_osc_en_reg == ($past(src) == 3'h4))
    else $error("low power enable does not follow select");
  chk_pins_quiet: assert property (
    !osc_pin_first_oe && !osc_pin_second_oe)
    else $error("oscillator pin driven digitally");
  chk_first_pin_use: assert property (
    osc_pin_first_analog_reg |-> osc_pin_second_analog_reg)
    else $error("first pin used without second");
  chk_spread_bound: assert property (stp <= 3'h6)
    else $error("spread step too deep");
  chk_spread_slope: assert property (
    $changed(stp) && stp != 3'h0 |->
      stp == $past(stp) + 3'h1 || stp == $past(stp) - 3'h1)
    else $error("spread step jumped");
  chk_sys_gated: assert property (
    src != 3'h1 && $past(src) != 3'h1 && $past(src, 2) != 3'h1
      |-> !ext_clk_sys_reg) else $error("system clock leaks");
  chk_sys_matches: assert property (
    src == 3'h1 && $past(src) == 3'h1 && $past(src, 2) == 3'h1
      |-> ext_clk_sys_reg == ext_clk_periph_reg)
    else $error("system and peripheral clocks differ");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid) else $error("write response late");
  chk_bvalid_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  cover property (stp == 3'h6);
  cover property (ext_clk_sys_reg);
  cover property (osc_pin_first_analog_reg);
endmodule // osc_source_ctrl_props

bind osc_source_ctrl osc_source_ctrl_props chk_u (
  .core_clk(core_clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .osc_pin_first_oe(osc_pin_first_oe),
  .osc_pin_second_oe(osc_pin_second_oe),
  .osc_pin_first_analog_reg(osc_pin_first_analog_reg),
  .osc_pin_second_analog_reg(osc_pin_second_analog_reg),
  .system_clock_source_field(system_clock_source_field),
  .low_power_osc_en_reg(low_power_osc_en_reg),
  .spread_step_reg(spread_step_reg),
  .ext_clk_periph_reg(ext_clk_periph_reg),
  .ext_clk_sys_reg(ext_clk_sys_reg));

// ===== bench/osc_ext_clock_model.sv
// Behavioural external oscillator on the second pin.
`timescale 1ns/10ps
module osc_ext_clock_model #(
  parameter FAST_NS = 75,
  parameter SLOW_NS = 125
) (
  input wire run,
  input wire slow,
  output reg pin
);
  // A stopped resonator rests low; the 5 ns offset keeps edges off the clock.
  initial begin
    pin = 1'b0;
    forever begin
      if (run) begin
        #(slow ? SLOW_NS : FAST_NS);
        pin = run ? ~pin : 1'b0;
      end else begin
        pin = 1'b0;
        @(run);
        #5;
      end
    end
  end
endmodule // osc_ext_clock_model

// ===== bench/oscillator_source_control_bench.sv
// Self-checking bench for the oscillator source control.
`timescale 1ns/10ps
module oscillator_source_control_bench;
  typedef struct packed {logic [3:0] a; logic [31:0] d; logic [31:0] q;
    logic [1:0] r;} osc_row_t;
  logic core_clk, rst_n, awv, wv, bre, arv, rre, ext_run, ext_slow;
  logic [3:0] awa, ara;
  logic [31:0] wd, q;
  logic [1:0] r;
  logic [2:0] mx, ps;
  wire awr, wr, bv, arr, rv, p1o, p1e, p1a, p2o, p2e, p2a;
  wire lp, xen, xper, xsys, ext_pin;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [2:0] src, step, fcode;
  wire [6:0] trim;
  wire pin2 = p2e ? p2o : ext_pin;
  wire pin1 = p1e ? p1o : ~ext_pin;
  integer n_errors = 0, checked = 0, i, t6, np, ns;
  osc_row_t tb[10] = '{
    '{4'h0, 32'h0, 32'h0, 2'h0}, '{4'h0, 32'h3, 32'h3, 2'h0},
    '{4'h0, 32'h5, 32'h3, 2'h0}, '{4'h4, 32'h25, 32'h25, 2'h0},
    '{4'hc, 32'hff, 32'h25, 2'h0}, '{4'h0, 32'h4, 32'h4, 2'h0},
    '{4'hc, 32'h0, 32'ha5, 2'h0}, '{4'h2, 32'h1, 32'h0, 2'h2},
    '{4'h8, 32'h35, 32'h35, 2'h0}, '{4'h8, 32'h66, 32'h66, 2'h0}};

  osc_source_ctrl #(.VALID_EDGES(4), .VALID_GAP(16)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre),
    .osc_pin_first_in(pin1), .osc_pin_first_out(p1o),
    .osc_pin_first_oe(p1e), .osc_pin_first_analog_reg(p1a),
    .osc_pin_second_in(pin2), .osc_pin_second_out(p2o),
    .osc_pin_second_oe(p2e), .osc_pin_second_analog_reg(p2a),
    .system_clock_source_field(src), .low_power_osc_en_reg(lp),
    .int_osc_trim_reg(trim), .spread_step_reg(step),
    .ext_osc_drive_freq_code(fcode), .ext_osc_en_reg(xen),
    .ext_clk_periph_reg(xper), .ext_clk_sys_reg(xsys));
  osc_ext_clock_model xo (.run(ext_run), .slow(ext_slow), .pin(ext_pin));

  task report_and_stop;
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] want);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: %h not %h", $time, seen, want);
    end
  endtask
  task bail;
    n_errors++;
    $display("unexpected at %0t: no answer", $time);
    report_and_stop;
  endtask
  task axw(input [3:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge core_clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
        if (awr) awv <= 1'b0;
        if (wr) wv <= 1'b0;
      end while (!bv && n < 50);
      if (!bv) bail;
      r = br;
      bre <= 1'b0;
    end
  endtask
  task axr(input [3:0] a);
    integer n;
    begin
      @(posedge core_clk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
        if (arr) arv <= 1'b0;
      end while (!rv && n < 50);
      if (!rv) bail;
      q = rdat;
      r = rr;
      rre <= 1'b0;
    end
  endtask
  task wait_valid(input [31:0] e);
    integer k;
    begin
      q = 32'h0;
      for (k = 0; k < 60 && !q[7]; k++) axr(4'h8);
      chk(q, e | 32'h80);
    end
  endtask
  task cnt(input integer len);
    begin
      np = 0;
      ns = 0;
      repeat (len) begin
        @(posedge core_clk);
        np += xper;
        ns += xsys;
      end
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    {rst_n, awv, wv, bre, arv, rre, ext_run, ext_slow} = 8'h0;
    {awa, ara, wd} = 40'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    for (i = 0; i < 10; i++) begin
      axw(tb[i].a, tb[i].d);
      chk(r, tb[i].r);
      axr(tb[i].a);
      chk(q, tb[i].q);
      chk(r, tb[i].r);
    end
    // Spread spectrum: period, depth and trim offset.
    axw(4'h4, 32'hc0);
    mx = 3'h0;
    t6 = -1;
    ps = step;
    for (i = 0; i < 800; i++) begin
      @(posedge core_clk);
      chk(trim, 7'h40 - ps);
      if (step == 3'h6 && ps != 3'h6) begin
        if (t6 >= 0) chk(i - t6, 384);
        t6 = i;
      end
      if (step > mx) mx = step;
      ps = step;
    end
    chk(mx, 3'h6);
    axw(4'h4, 32'h40);
    repeat (3) @(posedge core_clk);
    chk({trim, step}, {7'h40, 3'h0});
    // RC start-up, then capacitor mode; the bench waits for valid first.
    axw(4'h8, 32'h42);
    // Pin controls follow the mode register one cycle later.
    repeat (2) @(posedge core_clk);
    chk({p1a, p2a, p1e, p2e}, 4'h4);
    ext_run <= 1'b1;
    wait_valid(32'h42);
    axw(4'h0, 32'h1);
    cnt(60);
    chk({ns == np, np > 0}, 2'h3);
    axw(4'h8, 32'h52);
    axr(4'h8);
    chk(q, 32'h52);
    wait_valid(32'h52);
    axw(4'h0, 32'h4);
    repeat (2) @(posedge core_clk);
    chk(lp, 1'b1);
    for (i = 0; i < 8; i++) begin
      axw(4'h8, 32'h40 | i);
      chk(fcode, i);
    end
    axw(4'h8, 32'h0);
    axr(4'h8);
    chk(q, 32'h0);
    // CMOS clock: second pin digital, valid never set.
    axw(4'h8, 32'h21);
    cnt(60);
    axr(4'h8);
    chk(q, 32'h21);
    chk({p1a, p2a, np > 0, xen}, 4'h3);
    // Crystal with halving, slow resonator started after the drive.
    ext_run <= 1'b0;
    ext_slow <= 1'b1;
    axw(4'h8, 32'h77);
    repeat (2) @(posedge core_clk);
    chk({p1a, p2a, p1o, p2o}, 4'hc);
    ext_run <= 1'b1;
    wait_valid(32'h77);
    cnt(120);
    chk(np, 60);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({src, lp}, 4'h9);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    axr(4'h0);
    chk(q, 32'h4);
    axr(4'h4);
    chk(q, 32'h40);
    axr(4'h8);
    chk(q, 32'h0);
    report_and_stop;
  end
endmodule // oscillator_source_control_bench
